// ### core/gpcfg_pkg.sv
// Package with register map, reset values and bus states of the pad configuration bank
package gpcfg_pkg;
	localparam int          PINS          = 8;
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] OFF_DRIVE_2MA = 12'h500;
	localparam logic [11:0] OFF_DRIVE_4MA = 12'h504;
	localparam logic [11:0] OFF_DRIVE_8MA = 12'h508;
	localparam logic [11:0] OFF_OPEN_DRN  = 12'h50C;
	localparam logic [11:0] OFF_PULL_UP   = 12'h510;
	localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
	localparam logic [11:0] OFF_SLEW      = 12'h518;
	localparam logic [11:0] OFF_DIG_IN    = 12'h51C;
	localparam logic [7:0]  RST_DRIVE_2MA = 8'hFF;
	localparam logic [7:0]  RST_DRIVE_4MA = 8'h00;
	localparam logic [7:0]  RST_DRIVE_8MA = 8'h00;
	localparam logic [7:0]  RST_OPEN_DRN  = 8'h00;
	localparam logic [7:0]  RST_PULL_UP   = 8'hFF;
	localparam logic [7:0]  RST_PULL_DOWN = 8'h00;
	localparam logic [7:0]  RST_SLEW      = 8'h00;
	localparam logic [7:0]  RST_DIG_IN    = 8'hFF;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} gpcfg_bus_t;
endpackage : gpcfg_pkg

// ### core/gpcfg_pin.sv
// Per-pin exclusive selection: one-hot drive and pull with delayed hardware clear
`timescale 1ns/1ps
module gpcfg_pin (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Write strobes for this pin's bits, data bit
	input  wire logic       wr_2ma,
	input  wire logic       wr_4ma,
	input  wire logic       wr_8ma,
	input  wire logic       wr_pu,
	input  wire logic       wr_pd,
	input  wire logic       wdata,
	// Stored bits
	output logic            drive_2ma,
	output logic            drive_4ma,
	output logic            drive_8ma,
	output logic            pull_up,
	output logic            pull_down
);
	logic clr_2ma;
	logic clr_4ma;
	logic clr_8ma;
	logic clr_pu;
	logic clr_pd;

	// Clear requests wait one stage so they land on the second edge
	always_ff @(posedge clk) begin
		if (reset) begin
			clr_2ma <= 1'b0;
			clr_4ma <= 1'b0;
			clr_8ma <= 1'b0;
			clr_pu  <= 1'b0;
			clr_pd  <= 1'b0;
		end else begin
			clr_2ma <= (wr_4ma | wr_8ma) & wdata;
			clr_4ma <= (wr_2ma | wr_8ma) & wdata;
			clr_8ma <= (wr_2ma | wr_4ma) & wdata;
			clr_pu  <= wr_pd & wdata;
			clr_pd  <= wr_pu & wdata;
		end
	end

	// A direct write in the same cycle wins over a pending clear
	always_ff @(posedge clk) begin
		if (reset) begin
			drive_2ma <= gpcfg_pkg::RST_DRIVE_2MA[0];
			drive_4ma <= gpcfg_pkg::RST_DRIVE_4MA[0];
			drive_8ma <= gpcfg_pkg::RST_DRIVE_8MA[0];
			pull_up   <= gpcfg_pkg::RST_PULL_UP[0];
			pull_down <= gpcfg_pkg::RST_PULL_DOWN[0];
		end else begin
			if (wr_2ma) drive_2ma <= wdata;
			else if (clr_2ma) drive_2ma <= 1'b0;
			if (wr_4ma) drive_4ma <= wdata;
			else if (clr_4ma) drive_4ma <= 1'b0;
			if (wr_8ma) drive_8ma <= wdata;
			else if (clr_8ma) drive_8ma <= 1'b0;
			if (wr_pu) pull_up <= wdata;
			else if (clr_pu) pull_up <= 1'b0;
			if (wr_pd) pull_down <= wdata;
			else if (clr_pd) pull_down <= 1'b0;
		end
	end

	a_clear_4ma_delay: assert property (@(posedge clk) disable iff (reset)
		wr_2ma && wdata && !wr_4ma ##1 !wr_4ma |=> !drive_4ma)
		else $error("4 mA bit not cleared on second cycle");
	a_clear_2ma_delay: assert property (@(posedge clk) disable iff (reset)
		wr_8ma && wdata && !wr_2ma ##1 !wr_2ma |=> !drive_2ma)
		else $error("2 mA bit not cleared on second cycle");
	a_clear_8ma_delay: assert property (@(posedge clk) disable iff (reset)
		wr_4ma && wdata && !wr_8ma ##1 !wr_8ma |=> !drive_8ma)
		else $error("8 mA bit not cleared on second cycle");
	a_pull_exclusive: assert property (@(posedge clk) disable iff (reset)
		wr_pu && wdata && !wr_pd ##1 !wr_pd |=> pull_up && !pull_down)
		else $error("pull-up write did not clear pull-down");
	a_pulldown_wins: assert property (@(posedge clk) disable iff (reset)
		wr_pd && wdata && !wr_pu ##1 !wr_pu |=> pull_down && !pull_up)
		else $error("pull-down write did not clear pull-up");
	c_drive_8ma: cover property (@(posedge clk) disable iff (reset)
		wr_8ma && wdata ##2 drive_8ma && !drive_2ma);
	c_pull_down: cover property (@(posedge clk) disable iff (reset)
		wr_pd && wdata ##2 pull_down && !pull_up);
endmodule : gpcfg_pin

// ### core/gpcfg_regs.sv
// Pad configuration register bank with Avalon-MM slave and pad control outputs
`timescale 1ns/1ps
module gpcfg_regs #(
	parameter int PINS = gpcfg_pkg::PINS
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Avalon-MM slave
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Direction bits from the port's direction register
	input  wire logic [7:0]  pin_direction_reg,
	// Pad controls
	output logic [7:0]       pad_drive_2ma,
	output logic [7:0]       pad_drive_4ma,
	output logic [7:0]       pad_drive_8ma,
	output logic [7:0]       pad_open_drain_in,
	output logic [7:0]       pad_open_drain_out,
	output logic [7:0]       pad_pull_up,
	output logic [7:0]       pad_pull_down,
	output logic [7:0]       pad_slew_limit,
	output logic [7:0]       pad_digital_input
);
	logic [7:0]  drive_2ma_bits;
	logic [7:0]  drive_4ma_bits;
	logic [7:0]  drive_8ma_bits;
	logic [7:0]  open_drain_bits;
	logic [7:0]  pull_up_bits;
	logic [7:0]  pull_down_bits;
	logic [7:0]  slew_limit_bits;
	logic [7:0]  digital_input_bits;
	logic [7:0]  dir_meta;
	logic [7:0]  dir_sync;
	logic        wr_go;
	logic        rd_go;
	logic        low_lane;
	logic [31:0] next_readdata;
	gpcfg_pkg::gpcfg_bus_t bus_state;

	// Each access waits one cycle, then completes with waitrequest low
	assign wr_go    = avs_write & (bus_state == gpcfg_pkg::BUS_ACK);
	assign rd_go    = avs_read & (bus_state == gpcfg_pkg::BUS_ACK);
	assign low_lane = avs_byteenable[0];

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_state       <= gpcfg_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				gpcfg_pkg::BUS_IDLE: begin
					if (avs_read | avs_write) begin
						bus_state       <= gpcfg_pkg::BUS_ACK;
						avs_waitrequest <= 1'b0;
					end
				end
				gpcfg_pkg::BUS_ACK: begin
					bus_state       <= gpcfg_pkg::BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state       <= gpcfg_pkg::BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Only byte lane 0 holds pin bits; upper lanes are ignored
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			gpcfg_pin u_pin (
				.clk       (clk),
				.reset     (reset),
				.wr_2ma    (wr_go & low_lane & (avs_address == gpcfg_pkg::OFF_DRIVE_2MA)),
				.wr_4ma    (wr_go & low_lane & (avs_address == gpcfg_pkg::OFF_DRIVE_4MA)),
				.wr_8ma    (wr_go & low_lane & (avs_address == gpcfg_pkg::OFF_DRIVE_8MA)),
				.wr_pu     (wr_go & low_lane & (avs_address == gpcfg_pkg::OFF_PULL_UP)),
				.wr_pd     (wr_go & low_lane & (avs_address == gpcfg_pkg::OFF_PULL_DOWN)),
				.wdata     (avs_writedata[g]),
				.drive_2ma (drive_2ma_bits[g]),
				.drive_4ma (drive_4ma_bits[g]),
				.drive_8ma (drive_8ma_bits[g]),
				.pull_up   (pull_up_bits[g]),
				.pull_down (pull_down_bits[g])
			);
		end
	endgenerate

	// Plain read/write fields
	always_ff @(posedge clk) begin
		if (reset) begin
			open_drain_bits    <= gpcfg_pkg::RST_OPEN_DRN;
			slew_limit_bits    <= gpcfg_pkg::RST_SLEW;
			digital_input_bits <= gpcfg_pkg::RST_DIG_IN;
		end else if (wr_go && low_lane) begin
			if (avs_address == gpcfg_pkg::OFF_OPEN_DRN)
				open_drain_bits <= avs_writedata[7:0];
			if (avs_address == gpcfg_pkg::OFF_SLEW)
				slew_limit_bits <= avs_writedata[7:0];
			if (avs_address == gpcfg_pkg::OFF_DIG_IN)
				digital_input_bits <= avs_writedata[7:0];
		end
	end

	// Read mux; reserved and unmapped bits return zero
	always_comb begin
		next_readdata = gpcfg_pkg::UNMAPPED_DATA;
		case (avs_address)
			gpcfg_pkg::OFF_DRIVE_2MA: next_readdata[7:0] = drive_2ma_bits;
			gpcfg_pkg::OFF_DRIVE_4MA: next_readdata[7:0] = drive_4ma_bits;
			gpcfg_pkg::OFF_DRIVE_8MA: next_readdata[7:0] = drive_8ma_bits;
			gpcfg_pkg::OFF_OPEN_DRN:  next_readdata[7:0] = open_drain_bits;
			gpcfg_pkg::OFF_PULL_UP:   next_readdata[7:0] = pull_up_bits;
			gpcfg_pkg::OFF_PULL_DOWN: next_readdata[7:0] = pull_down_bits;
			gpcfg_pkg::OFF_SLEW:      next_readdata[7:0] = slew_limit_bits;
			gpcfg_pkg::OFF_DIG_IN:    next_readdata[7:0] = digital_input_bits;
			default:                  next_readdata = gpcfg_pkg::UNMAPPED_DATA;
		endcase
	end

	// Read data registered so it stands with waitrequest low
	always_ff @(posedge clk) begin
		if (reset) begin
			avs_readdata <= gpcfg_pkg::UNMAPPED_DATA;
		end else if (avs_read && bus_state == gpcfg_pkg::BUS_IDLE) begin
			avs_readdata <= next_readdata;
		end
	end

	// Direction comes from another block's register; resynchronised for safety
	always_ff @(posedge clk) begin
		if (reset) begin
			dir_meta <= 8'h00;
			dir_sync <= 8'h00;
		end else begin
			dir_meta <= pin_direction_reg;
			dir_sync <= dir_meta;
		end
	end

	// Pad controls from flip-flops
	always_ff @(posedge clk) begin
		if (reset) begin
			pad_drive_2ma      <= gpcfg_pkg::RST_DRIVE_2MA;
			pad_drive_4ma      <= gpcfg_pkg::RST_DRIVE_4MA;
			pad_drive_8ma      <= gpcfg_pkg::RST_DRIVE_8MA;
			pad_open_drain_in  <= 8'h00;
			pad_open_drain_out <= 8'h00;
			pad_pull_up        <= gpcfg_pkg::RST_PULL_UP;
			pad_pull_down      <= gpcfg_pkg::RST_PULL_DOWN;
			pad_slew_limit     <= gpcfg_pkg::RST_SLEW;
			pad_digital_input  <= gpcfg_pkg::RST_DIG_IN;
		end else begin
			pad_drive_2ma      <= drive_2ma_bits;
			pad_drive_4ma      <= drive_4ma_bits;
			pad_drive_8ma      <= drive_8ma_bits;
			pad_open_drain_in  <= open_drain_bits & ~dir_sync;
			pad_open_drain_out <= open_drain_bits & dir_sync;
			pad_pull_up        <= pull_up_bits;
			pad_pull_down      <= pull_down_bits;
			pad_slew_limit     <= slew_limit_bits & drive_8ma_bits;
			pad_digital_input  <= digital_input_bits;
		end
	end

	a_slew_needs_8ma: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> (pad_slew_limit & ~$past(drive_8ma_bits)) == 8'h00)
		else $error("slew limit active without 8 mA drive");
	a_od_direction: assert property (@(posedge clk) disable iff (reset)
		1'b1 |=> pad_open_drain_out == ($past(open_drain_bits) & $past(dir_sync)))
		else $error("open-drain output does not follow direction");
	a_upper_zero: assert property (@(posedge clk) disable iff (reset)
		!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	a_wait_release: assert property (@(posedge clk) disable iff (reset)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered in one cycle");
	a_reset_values: assert property (@(posedge clk)
		$past(reset) |-> drive_2ma_bits == 8'hFF && drive_4ma_bits == 8'h00
			&& drive_8ma_bits == 8'h00 && digital_input_bits == 8'hFF)
		else $error("reset values wrong");
	c_read_cycle: cover property (@(posedge clk) disable iff (reset)
		avs_read && !avs_waitrequest);
	c_od_output: cover property (@(posedge clk) disable iff (reset)
		pad_open_drain_out != 8'h00);
	c_slew_on: cover property (@(posedge clk) disable iff (reset)
		pad_slew_limit != 8'h00);
endmodule : gpcfg_regs

// ### dv/gpio_pad_config_regs_test.sv
// Self-checking bench for the pad configuration register bank
`timescale 1ns/1ps
module gpio_pad_config_regs_test;
	// Clock and reset
	logic        clk               = 1'b0;
	logic        reset             = 1'b1;
	// Avalon-MM master side
	logic [11:0] avs_address       = 12'h000;
	logic        avs_read          = 1'b0;
	logic        avs_write         = 1'b0;
	logic [31:0] avs_writedata     = 32'h00000000;
	logic [3:0]  avs_byteenable    = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	// Pins
	logic [7:0]  pin_direction_reg = 8'h00;
	logic [7:0]  pad [9];
	// Bench state
	logic [7:0]  model [8];
	logic [31:0] seed              = 32'h1353F215;
	logic [31:0] rdata;
	int          failures          = 0;
	int          checks_done       = 0;

	always #5 clk = ~clk;

	gpcfg_regs gpcfg_regs_i (
		.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pin_direction_reg(pin_direction_reg), .pad_drive_2ma(pad[0]), .pad_drive_4ma(pad[1]),
		.pad_drive_8ma(pad[2]), .pad_open_drain_in(pad[3]), .pad_open_drain_out(pad[4]),
		.pad_pull_up(pad[5]), .pad_pull_down(pad[6]), .pad_slew_limit(pad[7]),
		.pad_digital_input(pad[8])
	);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Index 8 stands for an unmapped address
	function automatic logic [11:0] addr_of(input int idx);
		return (idx < 8) ? 12'h500 + 12'(idx * 4) : 12'h520;
	endfunction : addr_of

	// Setting a drive or pull bit clears the same pin in its partner fields
	function automatic void model_write(input int idx, input logic [7:0] d);
		model[idx] = d;
		if (idx < 3) begin
			for (int j = 0; j < 3; j++)
				if (j != idx) model[j] = model[j] & ~d;
		end else if (idx == 4 || idx == 5) begin
			model[9 - idx] = model[9 - idx] & ~d;
		end
	endfunction : model_write

	function automatic logic [7:0] exp_pad(input int k);
		case (k)
			3: return model[3] & ~pin_direction_reg;
			4: return model[3] & pin_direction_reg;
			5: return model[4];
			6: return model[5];
			7: return model[6] & model[2];
			8: return model[7];
			default: return model[k];
		endcase
	endfunction : exp_pad

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: read got %h expected %h", $time, got, exp);
		end
	endtask : compare_word

	task automatic compare_pad(input int k, input logic [7:0] exp);
		checks_done++;
		if (pad[k] !== exp) begin
			failures++;
			$display("unexpected at %0t: pad group %0d got %h expected %h", $time, k, pad[k], exp);
		end
	endtask : compare_pad

	// Holds the request until waitrequest is sampled low, then returns at that edge
	task automatic bus(input logic wr, input int idx, input logic [7:0] d, input logic [3:0] be);
		avs_read       <= ~wr;
		avs_write      <= wr;
		avs_address    <= addr_of(idx);
		avs_writedata  <= {24'h000000, d};
		avs_byteenable <= be;
		for (int n = 0; n < 20; n++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0) begin
				rdata = avs_readdata;
				return;
			end
		end
		failures++;
		$display("unexpected at %0t: no answer from the bus", $time);
		final_report();
	endtask : bus

	task automatic idle(input int n);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic wr_reg(input int idx, input logic [7:0] d, input logic [3:0] be);
		bus(1'b1, idx, d, be);
		if (be[0] && idx < 8) model_write(idx, d);
	endtask : wr_reg

	task automatic rd_check(input int idx);
		bus(1'b0, idx, 8'h00, 4'h0);
		compare_word(rdata, (idx < 8) ? {24'h000000, model[idx]} : 32'h00000000);
	endtask : rd_check

	task automatic check_pads();
		idle(5);
		for (int k = 0; k < 9; k++)
			compare_pad(k, exp_pad(k));
	endtask : check_pads

	task automatic reset_test(input int n);
		reset <= 1'b1;
		repeat (n) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		model = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF};
		for (int i = 0; i < 9; i++)
			rd_check(i);
		check_pads();
		$display("test reset done");
	endtask : reset_test

	initial begin
		logic [31:0] r;
		int          clr [5];
		int          wrt [5];
		int          idx;
		clr = '{0, 1, 2, 4, 5};
		wrt = '{1, 2, 0, 5, 4};
		reset_test(16);
		// Hardware clear lands one edge after the write lands
		for (int t = 0; t < 5; t++) begin
			wr_reg(clr[t], 8'hFF, 4'hF);
			idle(3);
			wr_reg(wrt[t], 8'h5A, 4'hF);
			idle(1);
			@(posedge clk);
			compare_pad((clr[t] < 3) ? clr[t] : clr[t] + 1, 8'hFF);
			@(posedge clk);
			compare_pad((clr[t] < 3) ? clr[t] : clr[t] + 1, 8'hA5);
		end
		// Pins 3:0 taken as comparator inputs, so only they lose the digital input
		wr_reg(7, 8'hF0, 4'hF);
		check_pads();
		$display("test delayed clear done");
		// Random writes, read back at once, lane 0 masking and unmapped places among them
		repeat (80) begin
			r = rnd();
			idx = int'(r[7:0]) % 9;
			if (r[25]) pin_direction_reg <= r[31:24];
			wr_reg(idx, r[8] ? (8'h01 << r[11:9]) : r[19:12], r[20] ? 4'hF : r[24:21]);
			// Open-drain pins keep their digital input enabled
			if (idx == 3 || idx == 7)
				wr_reg(7, model[7] | model[3], 4'hF);
			rd_check(idx);
			check_pads();
		end
		$display("test random traffic done");
		reset_test(2);
		final_report();
	end
endmodule : gpio_pad_config_regs_test
